// ---- hdl/poos_defines.vh ----
// Constants for the pulse output origin search block: register byte offsets,
// configuration field positions, reset values, timing, and mode, method, error and event codes.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef POOS_DEFINES_VH
`define POOS_DEFINES_VH

`define POOS_CLK_HZ 100000000
`define POOS_MS_US 1000
`define POOS_MS_CYC (`POOS_CLK_HZ / `POOS_MS_US)
`define POOS_RATE_MS 4
`define POOS_MAX_PPS 17'h186A0
`define POOS_PHASE_WRAP 27'h5F5E100
`define POOS_MON_MAX 14'h270F
`define POOS_SYNC_RST 5'h0F

`define POOS_A_CTRL 8'h00
`define POOS_A_CFG 8'h04
`define POOS_A_PWR 8'h08
`define POOS_A_INIT 8'h0C
`define POOS_A_HIGH 8'h10
`define POOS_A_PROX 8'h14
`define POOS_A_CORR 8'h18
`define POOS_A_ACC 8'h1C
`define POOS_A_DEC 8'h20
`define POOS_A_MON 8'h24
`define POOS_A_STAT 8'h28
`define POOS_A_POS 8'h2C
`define POOS_A_ERR 8'h30
`define POOS_A_ISTAT 8'h34
`define POOS_A_IMASK 8'h38
`define POOS_A_RATE 8'h3C

`define POOS_CTRL_START 0
`define POOS_CTRL_STOP 1
`define POOS_CFG_LIM_ALWAYS 0
`define POOS_CFG_LIM_NO 1
`define POOS_CFG_CLR_ORG 2
`define POOS_CFG_SCURVE 3
`define POOS_CFG_DIR_CCW 4
`define POOS_CFG_LIM_STOP 5
`define POOS_CFG_MODE_LO 6
`define POOS_CFG_ORG_NO 8
`define POOS_CFG_PROX_NO 9
`define POOS_PWR_EN 0
`define POOS_PWR_METH_LO 1

`define POOS_CFG_RST 10'h000
`define POOS_PWR_RST 3'h0
`define POOS_MODE_INP 2'h2
`define POOS_METH_ONOFF 2'h0
`define POOS_METH_ON 2'h1
`define POOS_METH_NONE 2'h2
`define POOS_ERR_TIMEOUT 16'h0300
`define POOS_ERR_LIMIT 16'h0201

`define POOS_EV_DONE 0
`define POOS_EV_ERR 1
`define POOS_EV_LIMIT 2
`define POOS_EV_ORIGIN 3

`endif

// ---- hdl/poos_origin_search.v ----
// Origin search and limit handling for one pulse output channel, with an
// AXI4-Lite register port, a step/direction pulse output and an interrupt.
// Assumes sensor and drive inputs are asynchronous and aclk is 100 MHz.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "poos_defines.vh"
module poos_origin_search
#(
    parameter [31:0] MS_CYC = `POOS_MS_CYC
)
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cw_limit_in,
    input wire ccw_limit_in,
    input wire prox_in,
    input wire origin_in,
    input wire in_position_input,
    output reg pulse_out,
    output reg dir_ccw_out,
    output reg irq
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_FAST = 3'h1;
    localparam [2:0] ST_APPR = 3'h2;
    localparam [2:0] ST_CORR = 3'h3;
    localparam [2:0] ST_MON = 3'h4;

    reg [9:0] cfg_r;
    reg [2:0] pwr_r;
    reg [31:0] init_r, high_r, prox_r, corr_r, acc_r, dec_r, mon_r;
    reg [3:0] istat_r, imask_r;
    reg [9:0] cfg_q;
    reg [16:0] init_q, high_q, prox_q;
    reg [31:0] corr_q;
    reg [15:0] acc_q, dec_q;
    reg [13:0] mon_q;
    reg en_q, pwr_done_r;
    reg [1:0] meth_q;
    reg [4:0] s1_r, s2_r;
    reg [2:0] st_r;
    reg [16:0] rate_r, target_r;
    reg [26:0] phase_r;
    reg dir_r, prox_seen_r, prox_off_r, no_origin_r, stop_err_r, lim_d_r;
    reg [31:0] pos_r, remain_r, ms_cnt_r;
    reg [1:0] ms4_cnt_r;
    reg [13:0] mon_cnt_r;
    reg [15:0] err_r;
    reg [3:0] ev;
    reg [31:0] rd_mux;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[8*i +: 8] = new_v[8*i +: 8];
        end
    endfunction

    function [16:0] clamp_pps;
        input [31:0] v;
        begin
            if (v > {15'h0000, `POOS_MAX_PPS})
                clamp_pps = `POOS_MAX_PPS;
            else
                clamp_pps = v[16:0];
        end
    endfunction

    wire wr_en = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    wire rd_en = s_axi_arready & s_axi_arvalid;
    wire [7:0] wa = s_axi_awaddr;
    wire [31:0] cfg_wr = merge({22'h0, cfg_r}, s_axi_wdata, s_axi_wstrb);
    wire ctrl_wr = wr_en & (wa == `POOS_A_CTRL) & s_axi_wstrb[0];
    wire start_cmd = ctrl_wr & s_axi_wdata[`POOS_CTRL_START];
    wire stop_cmd = ctrl_wr & s_axi_wdata[`POOS_CTRL_STOP];
    wire en_eff = pwr_done_r ? en_q : pwr_r[`POOS_PWR_EN];
    wire run = (st_r == ST_FAST) | (st_r == ST_APPR) | (st_r == ST_CORR);

    wire cw_act = s2_r[0] ^ ~cfg_q[`POOS_CFG_LIM_NO];
    wire ccw_act = s2_r[1] ^ ~cfg_q[`POOS_CFG_LIM_NO];
    wire prox_act = s2_r[2] ^ ~cfg_q[`POOS_CFG_PROX_NO];
    wire org_act = s2_r[3] ^ ~cfg_q[`POOS_CFG_ORG_NO];
    wire inp_act = s2_r[4];
    wire lim_en = cfg_q[`POOS_CFG_LIM_ALWAYS] | (st_r != ST_IDLE);
    wire lim_any = lim_en & (cw_act | ccw_act);
    wire lim_hit = run & (dir_r ? ccw_act : cw_act);

    wire ms_tick = (ms_cnt_r == MS_CYC - 32'h1);
    wire tick4 = ms_tick & (ms4_cnt_r == 2'h3);
    wire [27:0] phase_sum = {1'b0, phase_r} + {11'h000, rate_r};
    wire step = run & (phase_sum >= {1'b0, `POOS_PHASE_WRAP});
    wire [1:0] mode_q = cfg_q[`POOS_CFG_MODE_LO +: 2];

    // S-curve halves the step near the target.
    wire up = rate_r < target_r;
    wire [16:0] diff = up ? target_r - rate_r : rate_r - target_r;
    wire [15:0] step_raw = up ? acc_q : dec_q;
    wire near = cfg_q[`POOS_CFG_SCURVE] & ({1'b0, diff} < {step_raw, 2'b00});
    wire [15:0] step_eff = near ? step_raw - {1'b0, step_raw[15:1]} : step_raw;
    wire jump = (step_eff == 16'h0000) | ({1'b0, step_eff} >= diff);
    wire [16:0] rate_ramp = jump ? target_r
        : (up ? rate_r + {1'b0, step_eff} : rate_r - {1'b0, step_eff});

    wire org_ok = org_act & ((meth_q == `POOS_METH_NONE) | (meth_q == `POOS_METH_ON)
        | prox_off_r);

    // Synchronisers start at the idle pin levels so no false limit edge follows reset.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_r <= `POOS_SYNC_RST;
            s2_r <= `POOS_SYNC_RST;
        end
        else
        begin
            s1_r <= {in_position_input, origin_in, prox_in, ccw_limit_in, cw_limit_in};
            s2_r <= s1_r;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ms_cnt_r <= 32'h0;
            ms4_cnt_r <= 2'h0;
        end
        else if (ms_tick)
        begin
            ms_cnt_r <= 32'h0;
            ms4_cnt_r <= ms4_cnt_r + 2'h1;
        end
        else
            ms_cnt_r <= ms_cnt_r + 32'h1;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_en)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa > `POOS_A_RATE) | (wa[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_en)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr > `POOS_A_RATE) | (s_axi_araddr[1:0] != 2'h0)
                    ? 2'h2 : 2'h0;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always @*
    begin
        case (s_axi_araddr)
            `POOS_A_CFG: rd_mux = {22'h0, cfg_r};
            `POOS_A_PWR: rd_mux = {29'h0, pwr_r};
            `POOS_A_INIT: rd_mux = init_r;
            `POOS_A_HIGH: rd_mux = high_r;
            `POOS_A_PROX: rd_mux = prox_r;
            `POOS_A_CORR: rd_mux = corr_r;
            `POOS_A_ACC: rd_mux = acc_r;
            `POOS_A_DEC: rd_mux = dec_r;
            `POOS_A_MON: rd_mux = mon_r;
            `POOS_A_STAT: rd_mux = {17'h0, s2_r, meth_q, en_q, stop_err_r, no_origin_r,
                (st_r != ST_IDLE), dir_r, st_r};
            `POOS_A_POS: rd_mux = pos_r;
            `POOS_A_ERR: rd_mux = {16'h0, err_r};
            `POOS_A_ISTAT: rd_mux = {28'h0, istat_r};
            `POOS_A_IMASK: rd_mux = {28'h0, imask_r};
            `POOS_A_RATE: rd_mux = {15'h0, rate_r};
            default: rd_mux = 32'h0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r <= `POOS_CFG_RST;
            pwr_r <= `POOS_PWR_RST;
            init_r <= 32'h0;
            high_r <= 32'h0;
            prox_r <= 32'h0;
            corr_r <= 32'h0;
            acc_r <= 32'h0;
            dec_r <= 32'h0;
            mon_r <= 32'h0;
            imask_r <= 4'h0;
        end
        else if (wr_en)
        begin
            case (wa)
                `POOS_A_CFG: cfg_r <= cfg_wr[9:0];
                `POOS_A_PWR: pwr_r <= s_axi_wstrb[0] ? s_axi_wdata[2:0] : pwr_r;
                `POOS_A_INIT: init_r <= merge(init_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_HIGH: high_r <= merge(high_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_PROX: prox_r <= merge(prox_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_CORR: corr_r <= merge(corr_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_ACC: acc_r <= merge(acc_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_DEC: dec_r <= merge(dec_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_MON: mon_r <= merge(mon_r, s_axi_wdata, s_axi_wstrb);
                `POOS_A_IMASK: imask_r <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : imask_r;
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // Interrupt status: a new event wins over a write-one clear.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            istat_r <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_en & (wa == `POOS_A_ISTAT) & s_axi_wstrb[0])
                istat_r <= (istat_r & ~s_axi_wdata[3:0]) | ev;
            else
                istat_r <= istat_r | ev;
            irq <= |(istat_r & imask_r);
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q <= `POOS_CFG_RST;
            init_q <= 17'h0;
            high_q <= 17'h0;
            prox_q <= 17'h0;
            corr_q <= 32'h0;
            acc_q <= 16'h0;
            dec_q <= 16'h0;
            mon_q <= 14'h0;
            en_q <= 1'b0;
            meth_q <= `POOS_METH_ONOFF;
            pwr_done_r <= 1'b0;
            st_r <= ST_IDLE;
            rate_r <= 17'h0;
            target_r <= 17'h0;
            phase_r <= 27'h0;
            dir_r <= 1'b0;
            prox_seen_r <= 1'b0;
            prox_off_r <= 1'b0;
            no_origin_r <= 1'b1;
            stop_err_r <= 1'b0;
            lim_d_r <= 1'b0;
            pos_r <= 32'h0;
            remain_r <= 32'h0;
            mon_cnt_r <= 14'h0;
            err_r <= 16'h0;
            ev <= 4'h0;
            pulse_out <= 1'b0;
            dir_ccw_out <= 1'b0;
        end
        else
        begin
            ev <= 4'h0;
            lim_d_r <= lim_any;
            pulse_out <= step;
            dir_ccw_out <= dir_r;
            phase_r <= step ? phase_sum[26:0] - `POOS_PHASE_WRAP : (run ? phase_sum[26:0] : 27'h0);
            if (step)
                pos_r <= dir_r ? pos_r - 32'h1 : pos_r + 32'h1;
            if (lim_any & ~lim_d_r)
            begin
                ev[`POOS_EV_LIMIT] <= 1'b1;
                if (cfg_q[`POOS_CFG_CLR_ORG])
                    no_origin_r <= 1'b1;
            end
            if ((st_r == ST_FAST) | (st_r == ST_APPR))
            begin
                if (tick4)
                    rate_r <= rate_ramp;
            end
            if (stop_cmd)
            begin
                st_r <= ST_IDLE;
                rate_r <= 17'h0;
            end
            else
            begin
                case (st_r)
                    ST_IDLE:
                    begin
                        // Start moves nothing while search disabled; the first start after reset still latches the power-on method.
                        if (start_cmd & en_eff)
                        begin
                            pwr_done_r <= 1'b1;
                            en_q <= en_eff;
                            meth_q <= pwr_done_r ? meth_q : pwr_r[`POOS_PWR_METH_LO +: 2];
                            cfg_q <= cfg_r;
                            init_q <= clamp_pps(init_r);
                            high_q <= clamp_pps(high_r);
                            prox_q <= clamp_pps(prox_r);
                            corr_q <= corr_r;
                            acc_q <= acc_r[15:0];
                            dec_q <= dec_r[15:0];
                            mon_q <= (mon_r > {18'h00000, `POOS_MON_MAX}) ? `POOS_MON_MAX
                                : mon_r[13:0];
                            dir_r <= cfg_r[`POOS_CFG_DIR_CCW];
                            rate_r <= clamp_pps(init_r);
                            prox_seen_r <= 1'b0;
                            prox_off_r <= 1'b0;
                            stop_err_r <= 1'b0;
                            err_r <= 16'h0;
                            target_r <= clamp_pps(high_r);
                            st_r <= ST_FAST;
                        end
                        else if (start_cmd & ~pwr_done_r)
                        begin
                            pwr_done_r <= 1'b1;
                            meth_q <= pwr_r[`POOS_PWR_METH_LO +: 2];
                        end
                    end
                    ST_FAST, ST_APPR, ST_CORR:
                    begin
                        // Reverse or stop on a limit.
                        if (lim_hit & cfg_q[`POOS_CFG_LIM_STOP])
                        begin
                            st_r <= ST_IDLE;
                            rate_r <= 17'h0;
                            err_r <= `POOS_ERR_LIMIT;
                            stop_err_r <= 1'b1;
                            ev[`POOS_EV_ERR] <= 1'b1;
                        end
                        else if (lim_hit)
                        begin
                            dir_r <= ~dir_r;
                            rate_r <= init_q;
                            if (st_r == ST_CORR)
                                st_r <= ST_IDLE;
                        end
                        else if (st_r == ST_FAST)
                        begin
                            // Proximity moves to the approach phase.
                            if ((meth_q == `POOS_METH_NONE) | prox_act)
                            begin
                                prox_seen_r <= prox_act;
                                target_r <= prox_q;
                                st_r <= ST_APPR;
                            end
                        end
                        else if (st_r == ST_APPR)
                        begin
                            if (prox_act)
                                prox_seen_r <= 1'b1;
                            else if (prox_seen_r)
                                prox_off_r <= 1'b1;
                            // Origin zeroes the position and starts the correction move; the train stops at once only with a zero offset.
                            if (org_ok)
                            begin
                                ev[`POOS_EV_ORIGIN] <= 1'b1;
                                pos_r <= 32'h0;
                                rate_r <= prox_q;
                                // Correction move by the signed offset.
                                dir_r <= corr_q[31];
                                remain_r <= corr_q[31] ? 32'h0 - corr_q : corr_q;
                                if (corr_q != 32'h0)
                                    st_r <= ST_CORR;
                                else
                                begin
                                    rate_r <= 17'h0;
                                    st_r <= ST_MON;
                                    mon_cnt_r <= 14'h0;
                                end
                            end
                        end
                        else if (step)
                        begin
                            remain_r <= remain_r - 32'h1;
                            if (remain_r == 32'h1)
                            begin
                                rate_r <= 17'h0;
                                st_r <= ST_MON;
                                mon_cnt_r <= 14'h0;
                            end
                        end
                    end
                    ST_MON:
                    begin
                        if ((mode_q != `POOS_MODE_INP) | inp_act)
                        begin
                            st_r <= ST_IDLE;
                            no_origin_r <= 1'b0;
                            ev[`POOS_EV_DONE] <= 1'b1;
                        end
                        // Timeout raises code and stop flag.
                        else if (mon_cnt_r >= mon_q)
                        begin
                            st_r <= ST_IDLE;
                            err_r <= `POOS_ERR_TIMEOUT;
                            stop_err_r <= 1'b1;
                            ev[`POOS_EV_ERR] <= 1'b1;
                        end
                        else if (ms_tick)
                            mon_cnt_r <= mon_cnt_r + 14'h1;
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

// ---- test/poos_checker_assertions.sv ----
// Checker for the origin search block: bus handshakes and step spacing.
// Sees only the top module's ports; bound to every instance.
`timescale 1ns/100ps
module poos_checker
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire pulse_out,
    input wire irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_w_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data taken apart");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    a_b_after: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid after handshake");
    a_r_after: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid after handshake");
    a_pulse_gap: assert property (pulse_out |=> !pulse_out [*8])
        else $error("steps faster than top rate");
    c_pulse: cover property (pulse_out);
    c_irq: cover property ($rose(irq));
    c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind poos_origin_search poos_checker chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .pulse_out, .irq);

// ---- test/poos_drive_model.sv ----
// Drive with sensors: counts steps and shows limit, origin, in-position.
// Assumes one pulse per step with direction already settled.
`timescale 1ns/100ps
module poos_drive_model
(
    input wire aclk,
    input wire aresetn,
    input wire pulse_out,
    input wire dir_ccw_out,
    input wire [31:0] org_at,
    input wire [31:0] lim_at,
    input wire inp_on,
    output wire cw_limit_in,
    output wire ccw_limit_in,
    output wire prox_in,
    output wire origin_in,
    output reg in_position_input,
    output reg [31:0] pos
);
    reg [11:0] quiet_r;
    assign cw_limit_in = $signed(pos) < $signed(lim_at);
    assign ccw_limit_in = 1'b1;
    assign origin_in = $signed(pos) < $signed(org_at);
    assign prox_in = origin_in;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pos <= 32'h0;
            quiet_r <= 12'h0;
            in_position_input <= 1'b0;
        end
        else
        begin
            if (pulse_out)
                pos <= dir_ccw_out ? pos - 32'h1 : pos + 32'h1;
            quiet_r <= pulse_out ? 12'h0 : quiet_r + {11'h0, quiet_r != 12'hFFF};
            in_position_input <= inp_on && quiet_r > 12'h4B0;
        end
    end
endmodule

// ---- test/test_pulse_output_origin_search.sv ----
// Bench: defaults, disabled start, search with correction, timeout, limit stop, ramp.
// Assumes the drive model on the sensor pins and the bound checker.
`timescale 1ns/100ps
`include "poos_defines.vh"
module test_pulse_output_origin_search;
    reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inp_on;
    reg [7:0] awaddr, araddr, a;
    reg [31:0] wdata, org_at, lim_at, rdat;
    reg [1:0] resp;
    reg rate_ok;
    wire awready, wready, bvalid, arready, rvalid, pulse, dir, irq, cw, ccw, prox, org, inp;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, pos;
    integer checks, n_mismatch, tmo, exp_pos;
    poos_origin_search #(.MS_CYC(32'h14)) dut_u
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cw_limit_in(cw), .ccw_limit_in(ccw), .prox_in(prox), .origin_in(org),
        .in_position_input(inp), .pulse_out(pulse), .dir_ccw_out(dir), .irq(irq)
    );
    poos_drive_model drv_u
    (
        .aclk(aclk), .aresetn(aresetn), .pulse_out(pulse), .dir_ccw_out(dir),
        .org_at(org_at), .lim_at(lim_at), .inp_on(inp_on), .cw_limit_in(cw),
        .ccw_limit_in(ccw), .prox_in(prox), .origin_in(org), .in_position_input(inp),
        .pos(pos)
    );
    task give_verdict;
        begin
            $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // One shared bound cuts every wait short.
    task step;
        begin
            @(posedge aclk);
            tmo = tmo + 1;
            if (tmo > 90000)
            begin
                n_mismatch = n_mismatch + 1;
                give_verdict;
            end
        end
    endtask
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e)
            begin
                n_mismatch = n_mismatch + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        begin
            awaddr <= ad;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            step;
            while (awready !== 1'b1)
                step;
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            while (bvalid !== 1'b1)
                step;
            bready <= 1'b0;
            step;
        end
    endtask
    task rd(input [7:0] ad);
        begin
            araddr <= ad;
            arvalid <= 1'b1;
            step;
            while (arready !== 1'b1)
                step;
            arvalid <= 1'b0;
            while (rvalid !== 1'b1)
                step;
            rready <= 1'b1;
            step;
            rdat = rdata;
            resp = rresp;
            rready <= 1'b0;
            step;
        end
    endtask
    task rc(input [7:0] ad, input [31:0] m, input [31:0] e, input [63:0] nm);
        begin
            rd(ad);
            chk(nm, e, rdat & m);
        end
    endtask
    task run;
        begin
            wr(`POOS_A_CTRL, 32'h1);
            rd(`POOS_A_STAT);
            while (rdat[4] !== 1'b0)
                rd(`POOS_A_STAT);
        end
    endtask
    initial
    begin
        aclk = 1'b0;
        forever
            #5 aclk = ~aclk;
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, inp_on} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        {org_at, lim_at} = {2{32'h7FFFFFFF}};
        {checks, n_mismatch, tmo} = {3{32'h0}};
        rdat = $urandom(32'hDD3B);
        step;
        step;
        aresetn <= 1'b1;
        step;
        rc(`POOS_A_CFG, 32'hFFFFFFFF, 32'h0, "cfg");
        rc(`POOS_A_PWR, 32'hFFFFFFFF, 32'h0, "pwr");
        rc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
        chk("resp", 32'h2, {30'h0, resp});
        run;
        rc(`POOS_A_STAT, 32'h3FF, 32'h20, "stat");
        chk("drive", 32'h0, pos);
        $display("test defaults done");
        aresetn <= 1'b0;
        step;
        step;
        aresetn <= 1'b1;
        step;
        org_at <= 32'h2 + ($urandom % 32'h4);
        inp_on <= 1'b1;
        wr(`POOS_A_PWR, {29'h0, `POOS_METH_NONE, 1'b1});
        wr(`POOS_A_CFG, {24'h0, `POOS_MODE_INP, 6'h0});
        for (a = `POOS_A_INIT; a < `POOS_A_CORR; a = a + 8'h4)
            wr(a, {15'h0, `POOS_MAX_PPS});
        wr(`POOS_A_CORR, 32'hFFFFFFFD);
        wr(`POOS_A_MON, 32'h64);
        wr(`POOS_A_IMASK, 32'hF);
        run;
        exp_pos = org_at - 3;
        chk("drive", exp_pos, pos);
        rc(`POOS_A_POS, 32'hFFFFFFFF, 32'hFFFFFFFD, "pos");
        rc(`POOS_A_ISTAT, 32'hF, 32'h9, "istat");
        chk("irq", 32'h1, {31'h0, irq});
        wr(`POOS_A_ISTAT, 32'hF);
        rc(`POOS_A_STAT, 32'h60, 32'h0, "stat");
        chk("irq", 32'h0, {31'h0, irq});
        $display("test search done");
        inp_on <= 1'b0;
        wr(`POOS_A_CORR, 32'h0);
        wr(`POOS_A_MON, 32'h5);
        wr(`POOS_A_IMASK, 32'h0);
        run;
        rc(`POOS_A_ERR, 32'hFFFF, {16'h0, `POOS_ERR_TIMEOUT}, "err");
        rc(`POOS_A_ISTAT, 32'hF, 32'hA, "istat");
        rc(`POOS_A_STAT, 32'h40, 32'h40, "stat");
        chk("irq", 32'h0, {31'h0, irq});
        $display("test timeout done");
        lim_at <= pos + 32'h2;
        org_at <= 32'h7FFFFFFF;
        wr(`POOS_A_CFG, 32'h24);
        run;
        chk("drive", lim_at, pos);
        rc(`POOS_A_ERR, 32'hFFFF, {16'h0, `POOS_ERR_LIMIT}, "err");
        rc(`POOS_A_STAT, 32'h20, 32'h20, "stat");
        $display("test limit done");
        wr(`POOS_A_INIT, 32'hC350);
        wr(`POOS_A_ACC, 32'h4E20);
        wr(`POOS_A_CFG, 32'h10);
        wr(`POOS_A_CTRL, 32'h1);
        repeat (8)
        begin
            repeat (10)
                step;
            rd(`POOS_A_RATE);
            rate_ok = rdat == 32'h186A0
                || (rdat >= 32'hC350 && (rdat - 32'hC350) % 32'h4E20 == 32'h0);
            chk("ramp", 32'h1, {31'h0, rate_ok});
        end
        repeat (200)
            step;
        rc(`POOS_A_RATE, 32'hFFFFFFFF, 32'h186A0, "rate");
        wr(`POOS_A_CTRL, 32'h2);
        rc(`POOS_A_STAT, 32'h18, 32'h8, "stat");
        $display("test ramp done");
        give_verdict;
    end
endmodule
